// >>> verilog/rtu_diag_multiwrite_slave.sv
// RTU slave frame handler: diagnosis echo and continuous write
`timescale 1ns/1ps
`default_nettype none
`include "rtu_defs.svh"
module rtu_diag_multiwrite_slave #(
   parameter int unsigned MAX_WORDS  = `RTU_MAX_WORDS,
   parameter int unsigned GAP_CYCLES = 32'(`RTU_GAP_CYCLES)
) (
   // Clock and reset
   input  wire logic              I_CLK,
   input  wire logic              I_RESET,
   // Configuration and drive state
   input  wire logic [7:0]        I_SLAVE_ADDR,
   input  wire logic              I_DRIVE_RUNNING,
   // Received bytes from the line receiver
   input  wire logic [7:0]        I_RX_DATA,
   input  wire logic              I_RX_VALID,
   // Bytes toward the line transmitter
   output logic [7:0]             O_TX_DATA,
   output logic                   O_TX_VALID,
   input  wire logic              I_TX_READY,
   // Attribute lookup of the parameter being written
   output rtu_pkg::par_addr_t     O_ATTR_ADDR,
   input  wire rtu_pkg::par_attr_t I_ATTR,
   // Parameter write port
   output rtu_pkg::wr_req_t       O_WR,
   output logic                   O_WR_VALID,
   output logic                   O_WR_REFUSED,
   // Read permission check for the read command handler
   input  wire logic [15:0]       I_RD_ADDR,
   output logic                   O_RD_ALLOWED
);
   import rtu_pkg::*;

   localparam int unsigned MAXB  = 9 + 2 * MAX_WORDS;   // Largest accepted frame
   localparam int unsigned LW    = $clog2(MAXB + 1);
   localparam int unsigned CW    = $clog2(GAP_CYCLES + 1);
   localparam logic [CW-1:0] GAP  = CW'(GAP_CYCLES);
   localparam logic [CW-1:0] GAPM = CW'(GAP_CYCLES - 1);

   // Byte count field must fit one byte; gap needs two cycles; refused at elaboration
   if (MAX_WORDS < 1 || MAX_WORDS > 127 || GAP_CYCLES < 2)
   begin : g_bad_params
      $error("rtu slave: unsupported MAX_WORDS or GAP_CYCLES");
   end

   // CRC over one byte, reflected polynomial
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++)
         r = r[0] ? ((r >> 1) ^ `RTU_CRC_POLY) : (r >> 1);
      return r;
   endfunction : crc_step

   state_t          state_q, state_d;     // Frame handling state
   logic [7:0]      buf_q [MAXB];         // Received frame bytes
   logic [LW-1:0]   len_q, len_d;         // Bytes in the frame
   logic            ovf_q, ovf_d;         // Frame longer than buffer
   logic [CW-1:0]   cnt_q, cnt_d;         // Idle cycles on the line
   logic [15:0]     rcrc_q, rcrc_d;       // Running check of rx bytes
   logic [15:0]     tcrc_q, tcrc_d;       // Check of the write reply
   logic            mw_q, mw_d;           // Reply is a write acknowledge
   logic [2:0]      tx_idx_q, tx_idx_d;   // Reply byte position
   logic [7:0]      tx_data_q;            // Reply byte on the port
   logic [6:0]      w_q, w_d;             // Word being written
   logic [15:0]     waddr_q, waddr_d;     // Address of that word
   wr_req_t         wr_q;                 // Write port register
   logic            wr_valid_q;           // Write strobe
   logic            wr_refused_q;         // Refusal strobe

   // Line activity and frame capture
   wire             idle_done = (cnt_q == GAP);
   wire             take_byte = I_RX_VALID && (state_q == ST_RX) && (len_q != '0 || idle_done);  // [R11]
   wire             frame_end = (state_q == ST_RX) && (len_q != '0) && (cnt_q == GAPM) && !I_RX_VALID; // [R11]
   wire             tx_go     = (state_q == ST_TX) && I_TX_READY;

   // Field decode of the held frame
   wire [7:0]       f_cmd    = buf_q[1];
   wire [15:0]      f_sub    = {buf_q[2], buf_q[3]};
   wire [15:0]      f_start  = {buf_q[2], buf_q[3]};
   wire [15:0]      f_qty    = {buf_q[4], buf_q[5]};
   wire [7:0]       f_bytes  = buf_q[6];
   wire             addr_hit = (buf_q[0] == I_SLAVE_ADDR);
   // Residue zero means the low-first check bytes matched
   wire             crc_ok   = (rcrc_q == `RTU_CRC_GOOD);                      // [R12]
   wire             frame_ok = addr_hit && crc_ok && !ovf_q && (len_q >= LW'(`RTU_MIN_BYTES)); // [R13]
   wire             is_echo  = (f_cmd == `RTU_CMD_DIAG) && (len_q == LW'(`RTU_DIAG_BYTES))
                               && (f_sub == `RTU_SUB_ECHO);                    // [R2]
   wire             qty_ok   = (f_qty != 16'h0000) && (f_qty <= 16'(MAX_WORDS)); // [R3]
   wire             is_mw    = (f_cmd == `RTU_CMD_MWRITE) && qty_ok && (f_bytes == f_qty[6:0] * 8'h02)
                               && (len_q == LW'(9 + 2 * int'(f_qty[6:0])));    // [R4]
   wire [6:0]       last_w   = f_qty[6:0] - 7'h01;

   // Parameter address decode; alias bit is stripped off the group
   wire             ram_only = waddr_q[`RTU_RAM_BIT];                          // [R9]
   wire par_addr_t  dec_addr = '{group: waddr_q[15:8] & `RTU_GROUP_MASK, index: waddr_q[7:0]}; // [R6]
   wire [LW-1:0]    wpos     = LW'(7 + 2 * int'(w_q));
   wire [15:0]      wdata    = {buf_q[wpos], buf_q[wpos + LW'(1)]};
   wire             locked   = I_ATTR.lock_always || (I_ATTR.lock_run && I_DRIVE_RUNNING); // [R8]
   wire             wr_ok    = (dec_addr.group != `RTU_FACTORY_GROUP) && !locked; // [R7]

   // Reply byte selection for the position about to be shown
   wire             crc_lo   = mw_d && (tx_idx_d == `RTU_ACK_CRC_LO);
   wire             crc_hi   = mw_d && (tx_idx_d == `RTU_ACK_CRC_HI);
   wire [7:0]       tx_sel   = crc_lo ? tcrc_d[7:0] : crc_hi ? tcrc_d[15:8] : buf_q[LW'(tx_idx_d)]; // [R12]

   // Read gate: alias addresses and the factory group are invalid
   assign O_RD_ALLOWED = !I_RD_ADDR[`RTU_RAM_BIT]
                         && (I_RD_ADDR[15:8] != `RTU_FACTORY_GROUP);           // [R7] [R10]
   assign O_TX_VALID   = (state_q == ST_TX);
   assign O_TX_DATA    = tx_data_q;
   assign O_ATTR_ADDR  = dec_addr;
   assign O_WR         = wr_q;
   assign O_WR_VALID   = wr_valid_q;
   assign O_WR_REFUSED = wr_refused_q;

   // Next-state and counter logic
   always_comb
   begin
      state_d  = state_q;
      len_d    = len_q;
      ovf_d    = ovf_q;
      rcrc_d   = rcrc_q;
      tcrc_d   = tcrc_q;
      mw_d     = mw_q;
      tx_idx_d = tx_idx_q;
      w_d      = w_q;
      waddr_d  = waddr_q;
      // Any line activity restarts the idle count
      if (I_RX_VALID || state_q == ST_TX)
         cnt_d = '0;
      else if (!idle_done)
         cnt_d = cnt_q + CW'(1);
      else
         cnt_d = cnt_q;
      case (state_q)
         ST_RX:
         begin
            // Bytes beyond the buffer mark the frame as bad
            if (take_byte)
            begin
               rcrc_d = crc_step((len_q == '0) ? `RTU_CRC_INIT : rcrc_q, I_RX_DATA);
               if (len_q == LW'(MAXB))
                  ovf_d = 1'b1;
               else
                  len_d = len_q + LW'(1);
            end
            if (frame_end)
               state_d = ST_CHECK;
         end
         ST_CHECK:
         begin
            tx_idx_d = '0;
            tcrc_d   = `RTU_CRC_INIT;
            w_d      = '0;
            waddr_d  = f_start;
            len_d    = '0;
            ovf_d    = 1'b0;
            // Unaddressed or corrupt frames get no answer at all
            if (frame_ok && is_echo)
            begin
               mw_d    = 1'b0;
               state_d = ST_TX;                                                // [R1]
            end
            else if (frame_ok && is_mw)
            begin
               mw_d    = 1'b1;
               state_d = ST_WRITE;                                             // [R3]
            end
            else
               state_d = ST_RX;                                                // [R13]
         end
         ST_WRITE:
         begin
            // One word per cycle; carry never reaches the alias bit
            w_d     = w_q + 7'h01;
            waddr_d = {waddr_q[15], waddr_q[14:0] + 15'h0001};
            if (w_q == last_w)
               state_d = ST_TX;
         end
         ST_TX:
         begin
            if (tx_go)
            begin
               // Acknowledge check covers addr, cmd, start, quantity
               if (tx_idx_q < `RTU_ACK_CRC_LO)
                  tcrc_d = crc_step(tcrc_q, tx_data_q);                        // [R5]
               tx_idx_d = tx_idx_q + 3'h1;
               if (tx_idx_q == `RTU_ACK_CRC_HI)
                  state_d = ST_GAP;
            end
         end
         ST_GAP:
         begin
            // Hold the line quiet before listening again
            if (cnt_q == GAPM && !I_RX_VALID)
               state_d = ST_RX;                                                // [R11]
         end
         default:
            state_d = ST_RX;
      endcase
   end

   // Control registers
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         state_q  <= ST_RX;
         len_q    <= '0;
         ovf_q    <= 1'b0;
         cnt_q    <= '0;
         rcrc_q   <= `RTU_CRC_INIT;
         tcrc_q   <= `RTU_CRC_INIT;
         mw_q     <= 1'b0;
         tx_idx_q <= '0;
         w_q      <= '0;
         waddr_q  <= '0;
      end
      else
      begin
         state_q  <= state_d;
         len_q    <= len_d;
         ovf_q    <= ovf_d;
         cnt_q    <= cnt_d;
         rcrc_q   <= rcrc_d;
         tcrc_q   <= tcrc_d;
         mw_q     <= mw_d;
         tx_idx_q <= tx_idx_d;
         w_q      <= w_d;
         waddr_q  <= waddr_d;
      end
   end

   // Output registers for reply bytes and parameter writes
   always_ff @(posedge I_CLK or posedge I_RESET)
   begin
      if (I_RESET)
      begin
         tx_data_q    <= 8'h00;
         wr_q         <= '0;
         wr_valid_q   <= 1'b0;
         wr_refused_q <= 1'b0;
      end
      else
      begin
         // Echo reuses stored check bytes untouched
         tx_data_q    <= tx_sel;                                               // [R1]
         wr_valid_q   <= (state_q == ST_WRITE) && wr_ok;                       // [R8]
         wr_refused_q <= (state_q == ST_WRITE) && !wr_ok;
         if (state_q == ST_WRITE)
            wr_q <= '{addr: dec_addr, data: wdata, commit_nv: !ram_only};      // [R9]
      end
   end

   // Frame byte store; data only, so no reset is needed
   always_ff @(posedge I_CLK)
   begin
      if (take_byte && len_q != LW'(MAXB))
         buf_q[len_q] <= I_RX_DATA;
   end

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   sequence s_crc_lo_sent;
      O_TX_VALID && I_TX_READY && (tx_idx_q == `RTU_ACK_CRC_LO);
   endsequence
   sequence s_crc_hi_shown;
      O_TX_VALID && (tx_idx_q == `RTU_ACK_CRC_HI);
   endsequence

   property p_echo_data;
      O_TX_VALID && !mw_q |-> O_TX_DATA == buf_q[LW'(tx_idx_q)];
   endproperty
   a_echo_data: assert property (p_echo_data) else $error("echo byte differs from query"); // [R1]

   property p_diag_shape;
      (state_q == ST_CHECK) ##1 (state_q == ST_TX && !mw_q)
         |-> $past(len_q) == LW'(`RTU_DIAG_BYTES) && $past(f_sub) == `RTU_SUB_ECHO;
   endproperty
   a_diag_shape: assert property (p_diag_shape) else $error("echo for malformed diagnosis"); // [R2]

   property p_qty_max;
      state_q == ST_WRITE |-> f_qty >= 16'h0001 && f_qty <= 16'(MAX_WORDS) && w_q <= last_w;
   endproperty
   a_qty_max: assert property (p_qty_max) else $error("write word count out of range"); // [R3]

   property p_ack_crc;
      O_TX_VALID && mw_q && tx_idx_q == `RTU_ACK_CRC_LO |-> O_TX_DATA == tcrc_q[7:0];
   endproperty
   a_ack_crc: assert property (p_ack_crc) else $error("acknowledge check byte wrong"); // [R5]

   property p_crc_order;
      s_crc_lo_sent |=> s_crc_hi_shown and (!mw_q || O_TX_DATA == tcrc_q[15:8]);
   endproperty
   a_crc_order: assert property (p_crc_order) else $error("check high byte not after low"); // [R12]

   property p_group;
      O_WR_VALID |-> O_WR.addr.group == ($past(waddr_q[15:8]) & `RTU_GROUP_MASK)
                     && O_WR.addr.index == $past(waddr_q[7:0]);
   endproperty
   a_group: assert property (p_group) else $error("write address decode wrong"); // [R6]

   property p_factory;
      O_WR_VALID |-> O_WR.addr.group != `RTU_FACTORY_GROUP;
   endproperty
   a_factory: assert property (p_factory) else $error("factory group written"); // [R7]

   property p_lock;
      $past(state_q == ST_WRITE && locked) |-> !O_WR_VALID && O_WR_REFUSED;
   endproperty
   a_lock: assert property (p_lock) else $error("locked parameter written"); // [R8]

   property p_ram;
      O_WR_VALID |-> O_WR.commit_nv == !$past(waddr_q[15]);
   endproperty
   a_ram: assert property (p_ram) else $error("alias write committed to storage"); // [R9]

   property p_rd;
      I_RD_ADDR[15] |-> !O_RD_ALLOWED;
   endproperty
   a_rd: assert property (p_rd) else $error("alias read allowed"); // [R10]

   property p_gap;
      state_q == ST_CHECK |-> $past(cnt_q) == GAPM && $past(state_q) == ST_RX;
   endproperty
   a_gap: assert property (p_gap) else $error("frame closed before idle gap"); // [R11]

   property p_discard;
      state_q == ST_CHECK && !frame_ok |=> state_q == ST_RX && len_q == '0 && !O_TX_VALID;
   endproperty
   a_discard: assert property (p_discard) else $error("bad frame not discarded"); // [R13]

endmodule : rtu_diag_multiwrite_slave
`default_nettype wire

// >>> common/rtu_defs.svh
// Constants of the RTU diagnosis and multi-write slave
// Operation
// R1: Diagnosis sub-function zero echoes query byte-for-byte
// R2: Diagnosis frame: addr, cmd, sub, data, check
// R3: Continuous write stores up to sixteen words
// R4: Master sends addr, cmd, start, qty, count, data
// R5: Write reply echoes start and quantity, new check
// R6: Address high byte is group, low index
// R7: Factory reserved group refused for read, write
// R8: Run-locked and always-locked parameters refuse writes
// R9: Address bit 15 writes RAM copy only
// R10: Reads at RAM-only alias addresses are invalid
// R11: Frames separated by 3.5 character idle time
// R12: Check bytes last, low byte first
// R13: Wrong address or bad check: silent discard
`ifndef RTU_DEFS_SVH
`define RTU_DEFS_SVH
`define RTU_CMD_DIAG       8'h08
`define RTU_CMD_MWRITE     8'h10
`define RTU_SUB_ECHO       16'h0000
`define RTU_MAX_WORDS      16
`define RTU_DIAG_BYTES     4'h8
`define RTU_ACK_CRC_LO     3'h6
`define RTU_ACK_CRC_HI     3'h7
`define RTU_MIN_BYTES      4
`define RTU_CRC_INIT       16'hffff
`define RTU_CRC_POLY       16'ha001
`define RTU_CRC_GOOD       16'h0000
`define RTU_FACTORY_GROUP  8'h63
`define RTU_RAM_BIT        15
`define RTU_GROUP_MASK     8'h7f
`define RTU_CLK_HZ         64'd50000000
`define RTU_BAUD           64'd9600
`define RTU_CHAR_BITS      64'd11
`define RTU_GAP_HALF_CHARS 64'd7
`define RTU_GAP_CYCLES     ((`RTU_GAP_HALF_CHARS * `RTU_CHAR_BITS * `RTU_CLK_HZ + 64'd2 * `RTU_BAUD - 64'd1) \
                            / (64'd2 * `RTU_BAUD))
`endif

// >>> common/rtu_pkg.sv
// Types shared by the RTU diagnosis and multi-write slave
package rtu_pkg;
   // Parameter address after decode
   typedef struct packed {
      logic [7:0] group;
      logic [7:0] index;
   } par_addr_t;
   // One parameter write toward the parameter store
   typedef struct packed {
      par_addr_t   addr;
      logic [15:0] data;
      logic        commit_nv;
   } wr_req_t;
   // Protection attributes of one parameter
   typedef struct packed {
      logic lock_run;
      logic lock_always;
   } par_attr_t;
   // Frame handling states, Gray along rx-check-write-tx-gap
   typedef enum logic [2:0] {
      ST_RX    = 3'b000,
      ST_CHECK = 3'b001,
      ST_WRITE = 3'b011,
      ST_TX    = 3'b010,
      ST_GAP   = 3'b110
   } state_t;
endpackage : rtu_pkg

// >>> test/rtu_master_model.sv
// Serial bus master model: sends request bytes and takes reply bytes
`timescale 1ns/1ps
`default_nettype none
module rtu_master_model (
   // Clock
   input  wire logic       clk,
   // Request bytes toward the slave
   output logic [7:0]      rx_data,
   output logic            rx_valid,
   // Reply bytes from the slave
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_valid,
   output logic            tx_ready
);
   logic [7:0] rep[$];  // Reply bytes taken so far
   logic       slow;    // Stall every other reply cycle
   // Quiet line at time zero
   initial
   begin
      rx_data  = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
      slow     = 1'b0;
   end
   // Ready toggles when slow, so the slave must hold each byte
   always @(posedge clk)
   begin
      if (tx_valid && tx_ready)
         rep.push_back(tx_data);
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end
   // Idle line first, then one byte every other cycle
   task automatic send(input logic [7:0] f[$], input int lead);
      repeat (lead) @(posedge clk);
      foreach (f[i])
      begin
         @(posedge clk);
         rx_data  <= f[i];
         rx_valid <= 1'b1;
         @(posedge clk);
         rx_valid <= 1'b0;
         rx_data  <= ~f[i];  // Released line never shows a stale byte
      end
   endtask : send
endmodule : rtu_master_model
`default_nettype wire

// >>> test/rtu_diag_multiwrite_slave_tb.sv
// Self-checking bench of the RTU diagnosis and multi-write slave
`timescale 1ns/1ps
`default_nettype none
module rtu_diag_multiwrite_slave_tb;
   import rtu_pkg::*;
   typedef logic [7:0] bq_t[$];
   localparam int GAP = 20;  // Short frame gap keeps the run brief
   logic        clk, rst, running, rx_valid, tx_valid, tx_ready, wr_valid, wr_refused, rd_ok;
   logic [7:0]  slave_addr, rx_data, tx_data;
   logic [15:0] rd_addr;
   par_addr_t   attr_addr;
   par_attr_t   attr;
   wr_req_t     wr;
   wr_req_t     wrs[$];  // Accepted writes of the current frame
   int          refs, fails, comparisons;
   bq_t         q;
   rtu_diag_multiwrite_slave #(.MAX_WORDS(16), .GAP_CYCLES(GAP)) i_rtu_diag_multiwrite_slave (
      .I_CLK(clk), .I_RESET(rst), .I_SLAVE_ADDR(slave_addr), .I_DRIVE_RUNNING(running),
      .I_RX_DATA(rx_data), .I_RX_VALID(rx_valid), .O_TX_DATA(tx_data), .O_TX_VALID(tx_valid),
      .I_TX_READY(tx_ready), .O_ATTR_ADDR(attr_addr), .I_ATTR(attr), .O_WR(wr), .O_WR_VALID(wr_valid),
      .O_WR_REFUSED(wr_refused), .I_RD_ADDR(rd_addr), .O_RD_ALLOWED(rd_ok));
   rtu_master_model i_rtu_master_model (
      .clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready));
   // Index 30 is always locked, index 31 only while running
   assign attr = '{lock_run: attr_addr.index == 8'h31, lock_always: attr_addr.index == 8'h30};
   // Collect write strobes of the frame under test
   always @(posedge clk)
   begin
      if (wr_valid === 1'b1)
         wrs.push_back(wr);
      if (wr_refused === 1'b1)
         refs++;
   end
   // Free-running 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Count, report
   task automatic chk_n(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk_n
   task automatic chk_w(input wr_req_t got, input wr_req_t exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : chk_w
   // Byte strings: length first, then each byte
   task automatic chk_q(input bq_t got, input bq_t exp);
      chk_n(got.size(), exp.size());
      foreach (exp[i])
         if (i < got.size())
            chk_n({24'h0, got[i]}, {24'h0, exp[i]});
   endtask : chk_q
   // Appends the check, low byte first; flip spoils it on purpose
   function automatic bq_t fr(input bq_t f, input logic [15:0] flip);
      logic [15:0] c;
      c = 16'hffff;
      foreach (f[i])
      begin
         c = c ^ {8'h00, f[i]};
         repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
      c = c ^ flip;
      f.push_back(c[7:0]);
      f.push_back(c[15:8]);
      return f;
   endfunction : fr
   // Write request body; word i is {11+i, i}, high byte first
   function automatic bq_t wf(input logic [15:0] start, input int qty, input int n);
      bq_t f;
      f = {8'h02, 8'h10, start[15:8], start[7:0], 8'(qty >> 8), 8'(qty), 8'(2 * qty)};
      for (int i = 0; i < n; i++)
         f = {f, 8'h11 + 8'(i), 8'(i)};
      return f;
   endfunction : wf
   // Expected write: group drops the alias bit, alias skips storage
   function automatic wr_req_t we(input logic [15:0] a, input logic [15:0] d);
      return '{addr: '{group: {1'b0, a[14:8]}, index: a[7:0]}, data: d, commit_nv: ~a[15]};
   endfunction : we
   // One frame, then a fixed wait longer than any reply
   task automatic run(input bq_t f, input int lead);
      wrs.delete();
      refs = 0;
      i_rtu_master_model.rep.delete();
      i_rtu_master_model.send(f, lead);
      repeat (4 * GAP + 40) @(posedge clk);
   endtask : run
   task automatic t_echo();
      q = {8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'hab, 8'had, 8'h14};
      chk_q(fr(q[0:5], 16'h0000), q);
      i_rtu_master_model.slow = 1'b1;
      run(q, GAP + 2);
      chk_q(i_rtu_master_model.rep, q);
      chk_n(wrs.size(), 0);
      $display("test echo done");
   endtask : t_echo
   task automatic t_write();
      @(posedge clk);
      slave_addr <= 8'h02;
      q = {8'h02, 8'h10, 8'h00, 8'h04, 8'h00, 8'h02, 8'h04, 8'h13, 8'h88, 8'h00, 8'h32};
      run(fr(q, 16'h0000), GAP + 2);
      chk_n(wrs.size(), 2);
      if (wrs.size() == 2)
      begin
         chk_w(wrs[0], we(16'h0004, 16'h1388));
         chk_w(wrs[1], we(16'h0005, 16'h0032));
      end
      chk_q(i_rtu_master_model.rep, fr(q[0:5], 16'h0000));
      i_rtu_master_model.slow = 1'b0;
      $display("test write done");
   endtask : t_write
   task automatic t_max();
      q = wf(16'h8007, 16, 16);
      run(fr(q, 16'h0000), GAP + 2);
      chk_n(wrs.size(), 16);
      foreach (wrs[i])
         chk_w(wrs[i], we(16'h8007 + 16'(i), {8'h11 + 8'(i), 8'(i)}));
      chk_q(i_rtu_master_model.rep, fr(q[0:5], 16'h0000));
      run(fr(wf(16'h0100, 17, 17), 16'h0000), GAP + 2);
      chk_n(wrs.size() + i_rtu_master_model.rep.size(), 0);
      $display("test max done");
   endtask : t_max
   task automatic t_protect();
      logic [15:0] st[3];
      st = '{16'h0a01, 16'h6301, 16'he301};
      q = wf(16'h302f, 3, 3);
      for (int r = 1; r >= 0; r--)
      begin
         @(posedge clk);
         running <= r[0];
         run(fr(q, 16'h0000), GAP + 2);
         chk_n(wrs.size(), 2 - r);
         chk_n(refs, 1 + r);
         chk_q(i_rtu_master_model.rep, fr(q[0:5], 16'h0000));
      end
      foreach (st[i])
      begin
         run(fr(wf(st[i], 1, 1), 16'h0000), GAP + 2);
         chk_n(refs, 32'(i > 0));
         chk_n(wrs.size(), 32'(i == 0));
      end
      $display("test protect done");
   endtask : t_protect
   task automatic t_discard();
      q = {8'h02, 8'h08, 8'h00, 8'h00, 8'h5a, 8'ha5};
      run(fr(q, 16'h0001), GAP + 2);
      chk_n(i_rtu_master_model.rep.size(), 0);
      q[0] = 8'h03;
      run(fr(q, 16'h0000), GAP + 2);
      chk_n(i_rtu_master_model.rep.size(), 0);
      q[0] = 8'h02;
      q[3] = 8'h01;
      run(fr(q, 16'h0000), GAP + 2);
      chk_n(i_rtu_master_model.rep.size(), 0);
      q[3] = 8'h00;
      i_rtu_master_model.send(fr(q, 16'h0000), GAP + 2);
      run(fr(q, 16'h0000), GAP / 2);
      chk_n(i_rtu_master_model.rep.size() + wrs.size(), 0);
      run(fr(q, 16'h0000), GAP + 2);
      chk_q(i_rtu_master_model.rep, fr(q, 16'h0000));
      $display("test discard done");
   endtask : t_discard
   task automatic t_read();
      logic [15:0] a[6];
      a = '{16'h0506, 16'h0a01, 16'h62ff, 16'h8007, 16'h6300, 16'he300};
      foreach (a[i])
      begin
         @(posedge clk);
         rd_addr <= a[i];
         @(negedge clk);
         chk_n({31'h0, rd_ok}, 32'(i < 3));
      end
      $display("test read done");
   endtask : t_read
   // Single exit of the run
   task automatic close_out();
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   // Main sequence after 20 cycles of reset
   initial
   begin
      rst = 1'b1;
      running = 1'b0;
      slave_addr = 8'h01;
      rd_addr = 16'h0000;
      fails = 0;
      comparisons = 0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_echo();
      t_write();
      t_max();
      t_protect();
      t_discard();
      t_read();
      close_out();
   end
   // Whole run is near 2500 cycles; this only cuts a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      close_out();
   end
endmodule : rtu_diag_multiwrite_slave_tb
`default_nettype wire
